// [include/dsf_params.svh]
// Purpose: offsets, field positions and reset values of the status flag block
// Assumes: included by bare name; definitions only
// Notes: byte addresses on the register bus
`ifndef DSF_PARAMS_SVH
`define DSF_PARAMS_SVH
`define DSF_OFS_STATUS      8'h00
`define DSF_OFS_CORE_CTRL   8'h04
`define DSF_OFS_IRQ_CTRL    8'h08
`define DSF_BIT_ACC_A_OVF   15
`define DSF_BIT_ACC_B_OVF   14
`define DSF_BIT_ACC_A_SAT   13
`define DSF_BIT_ACC_B_SAT   12
`define DSF_BIT_ANY_OVF     11
`define DSF_BIT_ANY_SAT     10
`define DSF_BIT_LOOP        9
`define DSF_PRIO_HI         7
`define DSF_PRIO_LO         5
`define DSF_BIT_PRIO_TOP    3
`define DSF_BIT_NEST_DIS    15
`define DSF_RST_PRIO        3'h0
`define DSF_RST_BIT         1'b0
`define DSF_RESP_OKAY       2'h0
`define DSF_RESP_SLVERR     2'h2
`endif

// [include/dsf_pkg.sv]
// Purpose: types of the status flag block
// Assumes: dsf_params.svh gives the numbers
// Notes: whole module state is one struct
package dsf_pkg;
	typedef logic [2:0] dsf_prio_t;
	typedef logic [1:0] dsf_resp_t;
	typedef struct packed {
		logic        aw_held;
		logic [7:0]  aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		dsf_resp_t   bresp;
		logic        rvalid;
		logic [31:0] rdata;
		dsf_resp_t   rresp;
		logic        acc_a_overflow;
		logic        acc_b_overflow;
		logic        acc_a_sat_sticky;
		logic        acc_b_sat_sticky;
		logic        hw_loop_active;
		dsf_prio_t   priority_low_field;
		logic        priority_top_bit;
		logic        nesting_disable;
	} dsf_state_t;
endpackage

// [verilog/dsf_status_flags.sv]
// Purpose: upper half of the processor status word with priority control bits
// Assumes: event inputs come from core logic on clk; AXI4-Lite register access
// Notes: status at 0x00, core control at 0x04, interrupt control at 0x08
// Notes on behaviour
// (RQ1) Accumulator A overflow bit follows the current overflow state and is read-only.
// (RQ2) Bit 14 shows whether accumulator B has overflowed.
// (RQ3) Bit 13 goes high when accumulator A saturates and stays high until cleared.
// (RQ4) Bit 12 goes high when accumulator B saturates and stays high until cleared.
// (RQ5) The combined overflow bit is the OR of both overflow bits.
// (RQ6) The combined saturation bit is high while either sticky saturation bit is high.
// (RQ7) Bit 10 can only be read or cleared, and clearing it clears both sticky bits.
// (RQ8) Bit 9 is high while a hardware loop is executing.
// (RQ9) The priority level is the top bit from core control bit 3 above the 3-bit field.
// (RQ10) User interrupts are blocked whenever the top priority bit is one.
// (RQ11) The priority field is read-only while interrupt control bit 15 is one.
// (RQ12) The field sits at bits 7 to 5 and code 111 also blocks user interrupts.
`timescale 1ns/10ps
`include "dsf_params.svh"
module dsf_status_flags #(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              acc_a_ovf_now,
	input  wire logic              acc_b_ovf_now,
	input  wire logic              acc_a_sat_now,
	input  wire logic              acc_b_sat_now,
	input  wire logic              hw_loop_now,
	output logic [3:0]             priority_level,
	output logic                   user_irq_blocked
);
	import dsf_pkg::*;

	dsf_state_t  st_reg;
	dsf_state_t  st_next;
	logic [15:0] status_word;
	logic        wr_fire;
	logic        clr_a;
	logic        clr_b;
	logic        wr_hi;
	logic        wr_lo;

	always_comb begin
		status_word = 16'h0000;
		status_word[`DSF_BIT_ACC_A_OVF] = st_reg.acc_a_overflow;
		status_word[`DSF_BIT_ACC_B_OVF] = st_reg.acc_b_overflow;
		status_word[`DSF_BIT_ACC_A_SAT] = st_reg.acc_a_sat_sticky;
		status_word[`DSF_BIT_ACC_B_SAT] = st_reg.acc_b_sat_sticky;
		status_word[`DSF_BIT_ANY_OVF] = st_reg.acc_a_overflow | st_reg.acc_b_overflow; // RQ5
		status_word[`DSF_BIT_ANY_SAT] = st_reg.acc_a_sat_sticky | st_reg.acc_b_sat_sticky; // RQ6
		status_word[`DSF_BIT_LOOP] = st_reg.hw_loop_active;
		status_word[`DSF_PRIO_HI:`DSF_PRIO_LO] = st_reg.priority_low_field; // RQ12
	end

	assign s_axi_awready = !st_reg.aw_held && !st_reg.bvalid;
	assign s_axi_wready = !st_reg.w_held && !st_reg.bvalid;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign priority_level = {st_reg.priority_top_bit, st_reg.priority_low_field}; // RQ9
	assign user_irq_blocked = st_reg.priority_top_bit | (&st_reg.priority_low_field); // RQ10 RQ12

	assign wr_fire = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
	assign wr_hi = wr_fire && st_reg.w_strb[1];
	assign wr_lo = wr_fire && st_reg.w_strb[0];
	// a zero written to a sticky bit or to the combined bit clears it
	assign clr_a = wr_hi && (st_reg.aw_addr == `DSF_OFS_STATUS)
		&& (!st_reg.w_data[`DSF_BIT_ACC_A_SAT] || !st_reg.w_data[`DSF_BIT_ANY_SAT]); // RQ7
	assign clr_b = wr_hi && (st_reg.aw_addr == `DSF_OFS_STATUS)
		&& (!st_reg.w_data[`DSF_BIT_ACC_B_SAT] || !st_reg.w_data[`DSF_BIT_ANY_SAT]); // RQ7

	always_comb begin
		st_next = st_reg;
		st_next.acc_a_overflow = acc_a_ovf_now; // RQ1
		st_next.acc_b_overflow = acc_b_ovf_now; // RQ2
		st_next.hw_loop_active = hw_loop_now; // RQ8
		// a saturation in the clearing cycle wins over the clear
		st_next.acc_a_sat_sticky = (st_reg.acc_a_sat_sticky && !clr_a) || acc_a_sat_now; // RQ3
		st_next.acc_b_sat_sticky = (st_reg.acc_b_sat_sticky && !clr_b) || acc_b_sat_now; // RQ4
		if (s_axi_awvalid && s_axi_awready) begin
			st_next.aw_held = 1'b1;
			st_next.aw_addr = {s_axi_awaddr[7:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_next.w_held = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end
		if (wr_fire) begin
			st_next.aw_held = 1'b0;
			st_next.w_held = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = `DSF_RESP_OKAY;
			case (st_reg.aw_addr)
				`DSF_OFS_STATUS: begin
					if (wr_lo && !st_reg.nesting_disable) begin
						st_next.priority_low_field =
							st_reg.w_data[`DSF_PRIO_HI:`DSF_PRIO_LO]; // RQ11
					end
				end
				`DSF_OFS_CORE_CTRL: begin
					if (wr_lo) begin
						st_next.priority_top_bit = st_reg.w_data[`DSF_BIT_PRIO_TOP];
					end
				end
				`DSF_OFS_IRQ_CTRL: begin
					if (wr_hi) begin
						st_next.nesting_disable = st_reg.w_data[`DSF_BIT_NEST_DIS];
					end
				end
				default: begin
					st_next.bresp = `DSF_RESP_SLVERR;
				end
			endcase
		end else if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = 32'h0000_0000;
			st_next.rresp = `DSF_RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'b00})
				`DSF_OFS_STATUS: begin
					st_next.rdata[15:0] = status_word;
				end
				`DSF_OFS_CORE_CTRL: begin
					st_next.rdata[`DSF_BIT_PRIO_TOP] = st_reg.priority_top_bit;
				end
				`DSF_OFS_IRQ_CTRL: begin
					st_next.rdata[`DSF_BIT_NEST_DIS] = st_reg.nesting_disable;
				end
				default: begin
					st_next.rresp = `DSF_RESP_SLVERR;
				end
			endcase
		end else if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '0;
			st_reg.priority_low_field <= `DSF_RST_PRIO;
			st_reg.priority_top_bit <= `DSF_RST_BIT;
			st_reg.nesting_disable <= `DSF_RST_BIT;
		end else begin
			st_reg <= st_next;
		end
	end

	a_ovf_a_follow: assert property (@(posedge clk) disable iff (!nrst)
		##1 st_reg.acc_a_overflow == $past(acc_a_ovf_now))
		else $error("overflow A does not follow its source"); // RQ1
	a_ovf_b_follow: assert property (@(posedge clk) disable iff (!nrst)
		##1 status_word[14] == $past(acc_b_ovf_now))
		else $error("overflow B bit wrong"); // RQ2
	a_sat_a_sticky: assert property (@(posedge clk) disable iff (!nrst)
		acc_a_sat_now |=> st_reg.acc_a_sat_sticky ##1 (st_reg.acc_a_sat_sticky || $past(clr_a)))
		else $error("saturation A not sticky"); // RQ3
	a_sat_b_sticky: assert property (@(posedge clk) disable iff (!nrst)
		(st_reg.acc_b_sat_sticky && !clr_b) |=> st_reg.acc_b_sat_sticky)
		else $error("saturation B dropped without clear"); // RQ4
	a_any_ovf_or: assert property (@(posedge clk) disable iff (!nrst)
		##1 status_word[11] == ($past(acc_a_ovf_now) || $past(acc_b_ovf_now)))
		else $error("combined overflow wrong"); // RQ5
	a_any_sat_or: assert property (@(posedge clk) disable iff (!nrst)
		status_word[10] == (status_word[13] || status_word[12]))
		else $error("combined saturation wrong"); // RQ6
	a_any_sat_clear: assert property (@(posedge clk) disable iff (!nrst)
		(wr_hi && st_reg.aw_addr == 8'h00 && !st_reg.w_data[10] && !acc_a_sat_now
			&& !acc_b_sat_now) |=> !status_word[10])
		else $error("clearing combined saturation left a sticky bit"); // RQ7
	a_any_sat_noset: assert property (@(posedge clk) disable iff (!nrst)
		(!st_reg.acc_a_sat_sticky && !acc_a_sat_now) |=> !st_reg.acc_a_sat_sticky)
		else $error("saturation A set without event"); // RQ7
	a_loop_follow: assert property (@(posedge clk) disable iff (!nrst)
		$rose(status_word[9]) |-> $past(hw_loop_now))
		else $error("loop bit rose without loop"); // RQ8
	a_prio_concat: assert property (@(posedge clk) disable iff (!nrst)
		priority_level == {st_reg.priority_top_bit, status_word[7:5]})
		else $error("priority level not concatenated"); // RQ9
	a_top_blocks: assert property (@(posedge clk) disable iff (!nrst)
		priority_level[3] |-> user_irq_blocked)
		else $error("top priority bit does not block"); // RQ10
	a_prio_locked: assert property (@(posedge clk) disable iff (!nrst)
		st_reg.nesting_disable |=> $stable(st_reg.priority_low_field))
		else $error("priority field changed while locked"); // RQ11
	a_prio_seven: assert property (@(posedge clk) disable iff (!nrst)
		(status_word[7:5] == 3'h7) |-> user_irq_blocked)
		else $error("level seven does not block"); // RQ12
endmodule

// [sim/dsf_status_flags_tb.sv]
// Purpose: self-checking bench of the status flag block
// Assumes: registers reached over AXI4-Lite, one clock, flags driven at the rising edge
// Notes: each scenario reads the registers back; t_ovf, t_sat and t_loop also drive the flags
`timescale 1ns/10ps
`include "dsf_params.svh"
module dsf_status_flags_tb;
	localparam logic [7:0] ST = `DSF_OFS_STATUS, CC = `DSF_OFS_CORE_CTRL, IC = `DSF_OFS_IRQ_CTRL;
	localparam logic [1:0] OK = `DSF_RESP_OKAY, ER = `DSF_RESP_SLVERR;
	logic        clk = 1'b0, nrst = 1'b0;
	logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        ovf_a = 1'b0, ovf_b = 1'b0, sat_a = 1'b0, sat_b = 1'b0, loop = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, blocked;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [3:0]  level;
	int          num_errors = 0, cmp_count = 0, cycles = 0;
	always #20 clk = ~clk;
	dsf_status_flags dut (
		.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.acc_a_ovf_now(ovf_a), .acc_b_ovf_now(ovf_b), .acc_a_sat_now(sat_a),
		.acc_b_sat_now(sat_b), .hw_loop_now(loop), .priority_level(level),
		.user_irq_blocked(blocked)
	);
	task automatic give_verdict();
		if (num_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	// values seen right after the edge are those the edge sampled
	task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s, logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (!(bvalid && bready));
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (!(rvalid && rready));
		rready <= 1'b0;
		chk("rdata", ed, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask
	task automatic t_reset();
		rd(ST, 32'h0, OK);
		rd(CC, 32'h0, OK);
		rd(IC, 32'h0, OK);
		rd(8'h0c, 32'h0, ER);
		wr(8'h0c, 32'hffffffff, 4'hf, ER);
		rd(CC, 32'h0, OK);
	endtask
	task automatic t_ovf();
		ovf_a <= 1'b1;
		rd(ST, 32'h8800, OK);
		wr(ST, 32'h0, 4'h2, OK);
		rd(ST, 32'h8800, OK);
		ovf_a <= 1'b0;
		ovf_b <= 1'b1;
		rd(ST, 32'h4800, OK);
		ovf_b <= 1'b0;
		rd(ST, 32'h0, OK);
	endtask
	task automatic t_sat();
		sat_a <= 1'b1;
		sat_b <= 1'b1;
		@(posedge clk);
		sat_a <= 1'b0;
		sat_b <= 1'b0;
		rd(ST, 32'h3400, OK);
		wr(ST, 32'hdf00, 4'h2, OK);
		rd(ST, 32'h1400, OK);
		wr(ST, 32'hff00, 4'h2, OK);
		rd(ST, 32'h1400, OK);
		wr(ST, 32'hfb00, 4'h2, OK);
		rd(ST, 32'h0, OK);
		wr(ST, 32'hff00, 4'h2, OK);
		rd(ST, 32'h0, OK);
		// a saturation still present when the clear lands keeps the sticky bit
		sat_a <= 1'b1;
		wr(ST, 32'hfb00, 4'h2, OK);
		rd(ST, 32'h2400, OK);
		sat_a <= 1'b0;
		wr(ST, 32'hfb00, 4'h2, OK);
		rd(ST, 32'h0, OK);
		sat_b <= 1'b1;
		@(posedge clk);
		sat_b <= 1'b0;
		wr(ST, 32'hef00, 4'h2, OK);
		rd(ST, 32'h0, OK);
	endtask
	task automatic t_loop();
		loop <= 1'b1;
		rd(ST, 32'h0200, OK);
		loop <= 1'b0;
		rd(ST, 32'h0, OK);
	endtask
	task automatic t_prio();
		wr(ST, 32'h00a0, 4'h1, OK);
		wr(CC, 32'h8, 4'h1, OK);
		@(negedge clk);
		chk("level", 32'hd, {28'h0, level});
		chk("blocked", 32'h1, {31'h0, blocked});
		wr(CC, 32'h0, 4'h1, OK);
		wr(ST, 32'h00e0, 4'h1, OK);
		@(negedge clk);
		chk("level", 32'h7, {28'h0, level});
		chk("blocked", 32'h1, {31'h0, blocked});
		wr(IC, 32'h8000, 4'h2, OK);
		wr(ST, 32'h0040, 4'h1, OK);
		rd(ST, 32'h00e0, OK);
		wr(IC, 32'h0, 4'h2, OK);
		wr(ST, 32'h0, 4'h1, OK);
		@(negedge clk);
		chk("level", 32'h0, {28'h0, level});
		chk("blocked", 32'h0, {31'h0, blocked});
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			num_errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_ovf();
		t_sat();
		t_loop();
		t_prio();
		give_verdict();
	end
endmodule
